// ===== src/mfio_pkg.sv
package mfio_pkg;

    // Register indices, byte address = 4 x index
    localparam logic [15:0] MFIO_P4_LATCH_IDX = 16'h0004;
    localparam logic [15:0] MFIO_P6_LATCH_IDX = 16'h0006;
    localparam logic [15:0] MFIO_P4_DRIVE_IDX = 16'h000a;
    localparam logic [15:0] MFIO_P4_PIN_IDX   = 16'h000e;
    localparam logic [15:0] MFIO_P6_DIR_IDX   = 16'h0f9b;
    localparam logic [15:0] MFIO_P6_IE_IDX    = 16'h0f9c;
    localparam logic [15:0] MFIO_P5_LATCH_IDX = 16'h0010;
    localparam logic [15:0] MFIO_P5_PIN_IDX   = 16'h0011;
    localparam logic [15:0] MFIO_BITOP_IDX    = 16'h0012;

    // Bus byte addresses
    localparam logic [15:0] MFIO_P4_LATCH_ADDR = MFIO_P4_LATCH_IDX << 2;
    localparam logic [15:0] MFIO_P6_LATCH_ADDR = MFIO_P6_LATCH_IDX << 2;
    localparam logic [15:0] MFIO_P4_DRIVE_ADDR = MFIO_P4_DRIVE_IDX << 2;
    localparam logic [15:0] MFIO_P4_PIN_ADDR   = MFIO_P4_PIN_IDX << 2;
    localparam logic [15:0] MFIO_P6_DIR_ADDR   = MFIO_P6_DIR_IDX << 2;
    localparam logic [15:0] MFIO_P6_IE_ADDR    = MFIO_P6_IE_IDX << 2;
    localparam logic [15:0] MFIO_P5_LATCH_ADDR = MFIO_P5_LATCH_IDX << 2;
    localparam logic [15:0] MFIO_P5_PIN_ADDR   = MFIO_P5_PIN_IDX << 2;
    localparam logic [15:0] MFIO_BITOP_ADDR    = MFIO_BITOP_IDX << 2;

    // Reset values
    localparam logic [7:0] MFIO_P4_LATCH_RST = 8'hff;
    localparam logic [7:0] MFIO_P4_DRIVE_RST = 8'h00;
    localparam logic [4:0] MFIO_P5_LATCH_RST = 5'h1f;
    localparam logic [7:0] MFIO_P6_LATCH_RST = 8'h00;
    localparam logic [7:0] MFIO_P6_DIR_RST   = 8'h00;
    localparam logic [7:0] MFIO_P6_IE_RST    = 8'hff;

    // Port 4 shared pin positions, and port 6 key wakeup LSB
    localparam int MFIO_SER2_CLK_BIT = 6;
    localparam int MFIO_SER2_DO_BIT  = 5;
    localparam int MFIO_SER2_DI_BIT  = 4;
    localparam int MFIO_UART2_TX_BIT = 2;
    localparam int MFIO_UART2_RX_BIT = 1;
    localparam int MFIO_KEYWAKE_LSB  = 4;

    // Bit-operation register fields
    localparam int MFIO_BITOP_BIT_LSB  = 0;
    localparam int MFIO_BITOP_VAL_BIT  = 3;
    localparam int MFIO_BITOP_PORT_LSB = 4;
    localparam logic [1:0] MFIO_SEL_P4 = 2'h0;
    localparam logic [1:0] MFIO_SEL_P5 = 2'h1;
    localparam logic [1:0] MFIO_SEL_P6 = 2'h2;

    // Bus responses
    localparam logic [1:0] MFIO_RESP_OKAY   = 2'h0;
    localparam logic [1:0] MFIO_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        MFIO_W_WAIT = 3'b001,
        MFIO_W_DO   = 3'b010,
        MFIO_W_RESP = 3'b100
    } mfio_wstate_t;

    typedef struct packed {
        logic        awvalid;
        logic [15:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [15:0] araddr;
        logic        rready;
    } mfio_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } mfio_axi_rsp_t;

endpackage

// ===== src/mfio_sync.sv
`timescale 1ns/1ns
`default_nettype none

module mfio_sync
    import mfio_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             ref_clk_in,
    input  wire logic             reset_n_in,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } mfio_sync_state_t;

    mfio_sync_state_t state_reg;
    mfio_sync_state_t state_next;

    // Only stage two reads stage one
    always_comb begin
        state_next.first  = async_in;
        state_next.second = state_reg.first;
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.second;

endmodule

`default_nettype wire

// ===== src/mfio_ports.sv
`timescale 1ns/1ns
`default_nettype none

module mfio_ports
    import mfio_pkg::*;
(
    // Clock and reset
    input  wire logic          ref_clk_in,
    input  wire logic          reset_n_in,
    // Register bus
    input  wire mfio_axi_req_t axi_req_in,
    output mfio_axi_rsp_t      axi_rsp_out,
    // Port 4 pins
    input  wire logic [7:0]    port4_pin_in,
    output logic      [7:0]    port4_pin_out,
    output logic      [7:0]    port4_pin_oe_out,
    // Port 5 pins
    input  wire logic [4:0]    port5_pin_in,
    output logic      [4:0]    port5_pin_out,
    output logic      [4:0]    port5_pin_oe_out,
    // Port 6 pins
    input  wire logic [7:0]    port6_pin_in,
    output logic      [7:0]    port6_pin_out,
    output logic      [7:0]    port6_pin_oe_out,
    // Serial 2 and UART 2 drives, idle high
    input  wire logic          serial2_clock_drive_in,
    input  wire logic          serial2_data_out_in,
    input  wire logic          uart2_transmit_line_in,
    // Serial 2 and UART 2 receive side
    output logic               serial2_clock_line_out,
    output logic               serial2_data_in_out,
    output logic               uart2_receive_line_out,
    // Bus controller on port 5, 1 releases the line
    input  wire logic [4:0]    i2c_release_in,
    output logic      [4:0]    i2c_line_out,
    // Analog and key wakeup
    output logic      [7:0]    converter_input_select_out,
    output logic      [3:0]    keywake_line_out
);

    typedef struct packed {
        logic [7:0]   p4_latch;
        logic [7:0]   p4_drive;
        logic [4:0]   p5_latch;
        logic [7:0]   p6_latch;
        logic [7:0]   p6_dir;
        logic [7:0]   p6_ie;
        mfio_wstate_t wstate;
        logic         aw_have;
        logic [15:0]  awaddr;
        logic         w_have;
        logic [7:0]   wbyte;
        logic         wlane;
        mfio_axi_rsp_t rsp;
        logic [7:0]   p4_out;
        logic [7:0]   p4_oe;
        logic [4:0]   p5_out;
        logic [4:0]   p5_oe;
        logic [7:0]   p6_out;
        logic [7:0]   p6_oe;
        logic [7:0]   ana_sel;
        logic [3:0]   keywake;
        logic         ser_clk;
        logic         ser_din;
        logic         uart_rx;
        logic [4:0]   i2c_line;
    } mfio_state_t;

    mfio_state_t state_reg;
    mfio_state_t state_next;

    logic [20:0] pins_sync;
    logic [7:0]  p4_sync;
    logic [4:0]  p5_sync;
    logic [7:0]  p6_sync;

    // All pins synced together
    mfio_sync #(
        .WIDTH (21)
    ) u_pin_sync (
        .ref_clk_in (ref_clk_in),
        .reset_n_in (reset_n_in),
        .async_in   ({port6_pin_in, port5_pin_in, port4_pin_in}),
        .sync_out   (pins_sync)
    );

    assign p4_sync = pins_sync[7:0];
    assign p5_sync = pins_sync[12:8];
    assign p6_sync = pins_sync[20:13];

    // Port 6 data read value per bit
    function automatic logic [7:0] p6_read(input logic [7:0] dir,
                                           input logic [7:0] ie,
                                           input logic [7:0] latch,
                                           input logic [7:0] pin);
        p6_read = (dir & latch) | (~dir & ie & pin);
    endfunction

    // Register read; bit 8 flags a miss
    function automatic logic [8:0] reg_read(input logic [15:0] addr,
                                            input mfio_state_t s,
                                            input logic [7:0] p4p,
                                            input logic [4:0] p5p,
                                            input logic [7:0] p6p);
        if (addr == MFIO_P4_LATCH_ADDR) begin
            reg_read = {1'b0, s.p4_latch};
        end else if (addr == MFIO_P4_PIN_ADDR) begin
            reg_read = {1'b0, p4p};
        end else if (addr == MFIO_P4_DRIVE_ADDR) begin
            reg_read = {1'b0, s.p4_drive};
        end else if (addr == MFIO_P5_LATCH_ADDR) begin
            reg_read = {4'h0, s.p5_latch};
        end else if (addr == MFIO_P5_PIN_ADDR) begin
            reg_read = {4'h0, p5p};
        end else if (addr == MFIO_P6_LATCH_ADDR) begin
            reg_read = {1'b0, p6_read(s.p6_dir, s.p6_ie, s.p6_latch, p6p)};
        end else if (addr == MFIO_P6_DIR_ADDR) begin
            reg_read = {1'b0, s.p6_dir};
        end else if (addr == MFIO_P6_IE_ADDR) begin
            reg_read = {1'b0, s.p6_ie};
        end else if (addr == MFIO_BITOP_ADDR) begin
            reg_read = 9'h000;
        end else begin
            reg_read = 9'h100;
        end
    endfunction

    logic [8:0]  rd_word;
    logic [8:0]  bitop_base;
    logic [15:0] bitop_addr;
    logic [7:0]  bitop_val;
    logic [2:0]  bitop_bit;
    logic [1:0]  bitop_port;
    logic        wr_miss;
    logic [7:0]  p4_val;
    logic [4:0]  p5_val;

    // Bit op: read port as software would, change one bit
    always_comb begin
        bitop_bit  = state_reg.wbyte[MFIO_BITOP_BIT_LSB +: 3];
        bitop_port = state_reg.wbyte[MFIO_BITOP_PORT_LSB +: 2];
        if (bitop_port == MFIO_SEL_P4) begin
            bitop_addr = MFIO_P4_LATCH_ADDR;
        end else if (bitop_port == MFIO_SEL_P5) begin
            bitop_addr = MFIO_P5_LATCH_ADDR;
        end else begin
            bitop_addr = MFIO_P6_LATCH_ADDR;
        end
        // Port 6 input bits read pins, or 0 where the input enable is clear, so their latch may change
        bitop_base = reg_read(bitop_addr, state_reg, p4_sync, p5_sync,
                              p6_sync);
        bitop_val  = bitop_base[7:0];
        bitop_val[bitop_bit] = state_reg.wbyte[MFIO_BITOP_VAL_BIT];
    end

    // Registers, bus and pins
    always_comb begin
        state_next = state_reg;
        rd_word    = reg_read(axi_req_in.araddr, state_reg, p4_sync,
                              p5_sync, p6_sync);
        wr_miss    = 1'b0;

        // AW and W taken in either order
        if (axi_req_in.awvalid && state_reg.rsp.awready) begin
            state_next.aw_have = 1'b1;
            state_next.awaddr  = axi_req_in.awaddr;
        end
        if (axi_req_in.wvalid && state_reg.rsp.wready) begin
            state_next.w_have = 1'b1;
            state_next.wbyte  = axi_req_in.wdata[7:0];
            state_next.wlane  = axi_req_in.wstrb[0];
        end

        case (state_reg.wstate)
            MFIO_W_WAIT: begin
                if (state_next.aw_have && state_next.w_have) begin
                    state_next.wstate = MFIO_W_DO;
                end
            end
            MFIO_W_DO: begin
                // Only byte lane 0 holds register data
                if (state_reg.awaddr == MFIO_P4_LATCH_ADDR) begin
                    if (state_reg.wlane) begin
                        state_next.p4_latch = state_reg.wbyte;
                    end
                end else if (state_reg.awaddr == MFIO_P4_DRIVE_ADDR) begin
                    if (state_reg.wlane) begin
                        state_next.p4_drive = state_reg.wbyte;
                    end
                end else if (state_reg.awaddr == MFIO_P5_LATCH_ADDR) begin
                    if (state_reg.wlane) begin
                        state_next.p5_latch = state_reg.wbyte[4:0];
                    end
                end else if (state_reg.awaddr == MFIO_P6_LATCH_ADDR) begin
                    if (state_reg.wlane) begin
                        state_next.p6_latch = state_reg.wbyte;
                    end
                end else if (state_reg.awaddr == MFIO_P6_DIR_ADDR) begin
                    if (state_reg.wlane) begin
                        state_next.p6_dir = state_reg.wbyte;
                    end
                end else if (state_reg.awaddr == MFIO_P6_IE_ADDR) begin
                    if (state_reg.wlane) begin
                        state_next.p6_ie = state_reg.wbyte;
                    end
                end else if (state_reg.awaddr == MFIO_BITOP_ADDR) begin
                    if (state_reg.wlane) begin
                        if (bitop_port == MFIO_SEL_P4) begin
                            state_next.p4_latch = bitop_val;
                        end else if (bitop_port == MFIO_SEL_P5) begin
                            state_next.p5_latch = bitop_val[4:0];
                        end else if (bitop_port == MFIO_SEL_P6) begin
                            state_next.p6_latch = bitop_val;
                        end
                    end
                end else if (state_reg.awaddr == MFIO_P4_PIN_ADDR ||
                             state_reg.awaddr == MFIO_P5_PIN_ADDR) begin
                    wr_miss = 1'b0; // Pin state ignores writes
                end else begin
                    wr_miss = 1'b1;
                end
                state_next.aw_have    = 1'b0;
                state_next.w_have     = 1'b0;
                state_next.rsp.bvalid = 1'b1;
                state_next.rsp.bresp  = wr_miss ? MFIO_RESP_SLVERR
                                                : MFIO_RESP_OKAY;
                state_next.wstate     = MFIO_W_RESP;
            end
            MFIO_W_RESP: begin
                if (axi_req_in.bready) begin
                    state_next.rsp.bvalid = 1'b0;
                    state_next.wstate     = MFIO_W_WAIT;
                end
            end
            default: begin
                state_next.wstate = MFIO_W_WAIT;
            end
        endcase
        state_next.rsp.awready = !state_next.aw_have &&
                                 (state_next.wstate == MFIO_W_WAIT);
        state_next.rsp.wready  = !state_next.w_have &&
                                 (state_next.wstate == MFIO_W_WAIT);

        // Read answers one cycle after address
        if (state_reg.rsp.rvalid && axi_req_in.rready) begin
            state_next.rsp.rvalid = 1'b0;
        end
        if (axi_req_in.arvalid && state_reg.rsp.arready) begin
            state_next.rsp.rvalid = 1'b1;
            state_next.rsp.rdata  = {24'h000000, rd_word[7:0]};
            state_next.rsp.rresp  = rd_word[8] ? MFIO_RESP_SLVERR
                                               : MFIO_RESP_OKAY;
        end
        state_next.rsp.arready = !state_next.rsp.rvalid;

        // Port 4: latch 0 wins over peripherals
        p4_val = state_reg.p4_latch;
        p4_val[MFIO_SER2_CLK_BIT] = state_reg.p4_latch[MFIO_SER2_CLK_BIT]
                                    & serial2_clock_drive_in;
        p4_val[MFIO_SER2_DO_BIT]  = state_reg.p4_latch[MFIO_SER2_DO_BIT]
                                    & serial2_data_out_in;
        p4_val[MFIO_UART2_TX_BIT] = state_reg.p4_latch[MFIO_UART2_TX_BIT]
                                    & uart2_transmit_line_in;
        state_next.p4_out = p4_val;
        // Open-drain drives lows only
        state_next.p4_oe  = state_reg.p4_drive | ~p4_val;

        // Port 5 sinks only, so the bus and the latch wire-and
        p5_val = state_reg.p5_latch & i2c_release_in;
        state_next.p5_out = p5_val;
        state_next.p5_oe  = ~p5_val;

        // Port 6 outputs drive latch, enable ignored
        state_next.p6_out  = state_reg.p6_latch;
        state_next.p6_oe   = state_reg.p6_dir;
        state_next.ana_sel = ~state_reg.p6_dir & ~state_reg.p6_ie;
        state_next.keywake = p6_sync[MFIO_KEYWAKE_LSB +: 4]
                     & ~state_reg.p6_dir[MFIO_KEYWAKE_LSB +: 4];

        // Peripheral receive lines
        state_next.ser_clk  = p4_sync[MFIO_SER2_CLK_BIT];
        state_next.ser_din  = p4_sync[MFIO_SER2_DI_BIT];
        state_next.uart_rx  = p4_sync[MFIO_UART2_RX_BIT];
        state_next.i2c_line = p5_sync;
    end

    // State register
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            state_reg          <= '0;
            state_reg.p4_latch <= MFIO_P4_LATCH_RST;
            state_reg.p4_drive <= MFIO_P4_DRIVE_RST;
            state_reg.p5_latch <= MFIO_P5_LATCH_RST;
            state_reg.p5_out   <= MFIO_P5_LATCH_RST;
            state_reg.p6_latch <= MFIO_P6_LATCH_RST;
            state_reg.p6_dir   <= MFIO_P6_DIR_RST;
            state_reg.p6_ie    <= MFIO_P6_IE_RST;
            state_reg.wstate   <= MFIO_W_WAIT;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs from flops
    assign axi_rsp_out                = state_reg.rsp;
    assign port4_pin_out              = state_reg.p4_out;
    assign port4_pin_oe_out           = state_reg.p4_oe;
    assign port5_pin_out              = state_reg.p5_out;
    assign port5_pin_oe_out           = state_reg.p5_oe;
    assign port6_pin_out              = state_reg.p6_out;
    assign port6_pin_oe_out           = state_reg.p6_oe;
    assign serial2_clock_line_out     = state_reg.ser_clk;
    assign serial2_data_in_out        = state_reg.ser_din;
    assign uart2_receive_line_out     = state_reg.uart_rx;
    assign i2c_line_out               = state_reg.i2c_line;
    assign converter_input_select_out = state_reg.ana_sel;
    assign keywake_line_out           = state_reg.keywake;

endmodule

`default_nettype wire

// ===== dv/mfio_sva.sv
`timescale 1ns/1ns
`default_nettype none

module mfio_sva
    import mfio_pkg::*;
(
    // Clock and reset
    input wire logic          ref_clk_in,
    input wire logic          reset_n_in,
    // Register bus
    input wire mfio_axi_req_t axi_req_in,
    input wire mfio_axi_rsp_t axi_rsp_out,
    // Pins and receive lines
    input wire logic [7:0]    port4_pin_in,
    input wire logic [7:0]    port4_pin_out,
    input wire logic [7:0]    port4_pin_oe_out,
    input wire logic [4:0]    port5_pin_out,
    input wire logic [4:0]    port5_pin_oe_out,
    input wire logic [7:0]    port6_pin_in,
    input wire logic [7:0]    port6_pin_out,
    input wire logic [7:0]    port6_pin_oe_out,
    input wire logic          serial2_clock_line_out,
    input wire logic          serial2_data_in_out,
    input wire logic          uart2_receive_line_out,
    input wire logic [3:0]    keywake_line_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    logic [2:0]  up_reg;
    logic [15:0] raddr_reg;
    // Age since reset; sync flops start at 0
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) up_reg <= 3'h0;
        else if (up_reg != 3'h7) up_reg <= up_reg + 3'h1;
    end
    // Address of the read in flight
    always_ff @(posedge ref_clk_in) begin
        if (axi_req_in.arvalid && axi_rsp_out.arready)
            raddr_reg <= axi_req_in.araddr;
    end
    sequence wr_taken;
        axi_req_in.awvalid && axi_rsp_out.awready &&
        axi_req_in.wvalid && axi_rsp_out.wready;
    endsequence
    sequence rd_taken;
        axi_req_in.arvalid && axi_rsp_out.arready;
    endsequence
    reset_cfg_a: assert property ($rose(reset_n_in) |=> port4_pin_out == 8'hff
        && port4_pin_oe_out == 8'h00 && port6_pin_oe_out == 8'h00
        && port6_pin_out == 8'h00) else $error("reset pin state wrong");
    rd_latency_a: assert property (rd_taken |=> axi_rsp_out.rvalid)
        else $error("read answer late");
    rd_hold_a: assert property (axi_rsp_out.rvalid && !axi_req_in.rready
        |=> axi_rsp_out.rvalid && $stable(axi_rsp_out.rdata))
        else $error("read data dropped");
    wr_resp_a: assert property (wr_taken |=> !axi_rsp_out.bvalid
        ##1 axi_rsp_out.bvalid) else $error("write answer off");
    p5_upper_a: assert property (axi_rsp_out.rvalid
        && (raddr_reg == MFIO_P5_PIN_ADDR || raddr_reg == MFIO_P5_LATCH_ADDR)
        |-> axi_rsp_out.rdata[31:5] == 27'h0) else $error("p5 upper set");
    ser_sync_a: assert property (up_reg == 3'h7 |-> {serial2_clock_line_out,
        serial2_data_in_out, uart2_receive_line_out} == $past({port4_pin_in[6],
        port4_pin_in[4], port4_pin_in[1]}, 3)) else $error("rx lines off");
    keywake_a: assert property (up_reg == 3'h7 |-> keywake_line_out ==
        ($past(port6_pin_in[7:4], 3) & ~port6_pin_oe_out[7:4]))
        else $error("keywake wrong");
    p5_sink_a: assert property (port5_pin_oe_out == ~port5_pin_out)
        else $error("p5 drives high");
    ar_block_a: assert property (axi_rsp_out.rvalid |-> !axi_rsp_out.arready)
        else $error("read overlap");
endmodule

bind mfio_ports mfio_sva u_sva (.ref_clk_in, .reset_n_in, .axi_req_in,
    .axi_rsp_out, .port4_pin_in, .port4_pin_out, .port4_pin_oe_out,
    .port5_pin_out, .port5_pin_oe_out, .port6_pin_in, .port6_pin_out,
    .port6_pin_oe_out, .serial2_clock_line_out, .serial2_data_in_out,
    .uart2_receive_line_out, .keywake_line_out);

`default_nettype wire

// ===== dv/mfio_pins.sv
`timescale 1ns/1ns
`default_nettype none

module mfio_pins
    import mfio_pkg::*;
(
    // Device drive and enable
    input  wire logic [7:0] p4_out_in,
    input  wire logic [7:0] p4_oe_in,
    input  wire logic [4:0] p5_out_in,
    input  wire logic [4:0] p5_oe_in,
    input  wire logic [7:0] p6_out_in,
    input  wire logic [7:0] p6_oe_in,
    // Board levels where released
    input  wire logic [7:0] ext4_in,
    input  wire logic [4:0] ext5_in,
    input  wire logic [7:0] ext6_in,
    // Resolved pin levels
    output logic      [7:0] pin4_out,
    output logic      [4:0] pin5_out,
    output logic      [7:0] pin6_out
);
    // Enabled drive wins, else board
    assign pin4_out = (p4_oe_in & p4_out_in) | (~p4_oe_in & ext4_in);
    assign pin5_out = (p5_oe_in & p5_out_in) | (~p5_oe_in & ext5_in);
    assign pin6_out = (p6_oe_in & p6_out_in) | (~p6_oe_in & ext6_in);
endmodule

`default_nettype wire

// ===== dv/mfio_ports_test.sv
`timescale 1ns/1ns
`default_nettype none

module mfio_ports_test
    import mfio_pkg::*;
;
    logic          ref_clk_in;
    logic          reset_n_in;
    mfio_axi_req_t axi_req_in;
    mfio_axi_rsp_t axi_rsp_out;
    logic [7:0]    port4_pin_in, port4_pin_out, port4_pin_oe_out, ext4;
    logic [4:0]    port5_pin_in, port5_pin_out, port5_pin_oe_out, ext5;
    logic [7:0]    port6_pin_in, port6_pin_out, port6_pin_oe_out, ext6;
    logic          serial2_clock_drive_in, serial2_data_out_in;
    logic          uart2_transmit_line_in, serial2_clock_line_out;
    logic          serial2_data_in_out, uart2_receive_line_out;
    logic [4:0]    i2c_release_in, i2c_line_out;
    logic [7:0]    converter_input_select_out;
    logic [3:0]    keywake_line_out;
    logic [31:0]   rdv;
    logic [1:0]    rsp;
    int            n_fail, checks;

    mfio_ports dut (.ref_clk_in, .reset_n_in, .axi_req_in, .axi_rsp_out,
        .port4_pin_in, .port4_pin_out, .port4_pin_oe_out, .port5_pin_in,
        .port5_pin_out, .port5_pin_oe_out, .port6_pin_in, .port6_pin_out,
        .port6_pin_oe_out, .serial2_clock_drive_in, .serial2_data_out_in,
        .uart2_transmit_line_in, .serial2_clock_line_out,
        .serial2_data_in_out, .uart2_receive_line_out, .i2c_release_in,
        .i2c_line_out, .converter_input_select_out, .keywake_line_out);
    mfio_pins u_pins (.p4_out_in(port4_pin_out), .p4_oe_in(port4_pin_oe_out),
        .p5_out_in(port5_pin_out), .p5_oe_in(port5_pin_oe_out),
        .p6_out_in(port6_pin_out), .p6_oe_in(port6_pin_oe_out),
        .ext4_in(ext4), .ext5_in(ext5), .ext6_in(ext6),
        .pin4_out(port4_pin_in), .pin5_out(port5_pin_in),
        .pin6_out(port6_pin_in));

    // 50 ns clock
    initial begin
        ref_clk_in = 1'b0;
        forever #25 ref_clk_in = ~ref_clk_in;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask

    // Bounded wait ran out
    task automatic timeout_hit();
        $display("[ERR] bus answer expected 1 seen 0");
        n_fail++;
        final_report();
    endtask

    // Write: aw and w together, bready until bvalid
    task automatic wr(input logic [15:0] a, input logic [7:0] d,
                      output logic [1:0] r);
        int i;
        @(posedge ref_clk_in);
        axi_req_in.awaddr <= a;
        axi_req_in.wdata <= {24'h0, d};
        axi_req_in.awvalid <= 1'b1;
        axi_req_in.wvalid <= 1'b1;
        axi_req_in.bready <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge ref_clk_in);
            if (axi_rsp_out.awready) axi_req_in.awvalid <= 1'b0;
            if (axi_rsp_out.wready) axi_req_in.wvalid <= 1'b0;
            if (axi_rsp_out.bvalid) break;
        end
        axi_req_in.bready <= 1'b0;
        r = axi_rsp_out.bresp;
        if (i == 40) timeout_hit();
    endtask

    task automatic rd(input logic [15:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int i;
        @(posedge ref_clk_in);
        axi_req_in.araddr <= a;
        axi_req_in.arvalid <= 1'b1;
        axi_req_in.rready <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge ref_clk_in);
            if (axi_rsp_out.arready) axi_req_in.arvalid <= 1'b0;
            if (axi_rsp_out.rvalid) break;
        end
        axi_req_in.rready <= 1'b0;
        d = axi_rsp_out.rdata;
        r = axi_rsp_out.rresp;
        if (i == 40) timeout_hit();
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask

    // Reset reads; port 6 input reads pins
    logic [15:0] ra [6] = '{MFIO_P4_LATCH_ADDR, MFIO_P4_DRIVE_ADDR,
        MFIO_P5_LATCH_ADDR, MFIO_P6_LATCH_ADDR, MFIO_P6_DIR_ADDR,
        MFIO_P6_IE_ADDR};
    logic [7:0]  rv [6] = '{8'hff, 8'h00, 8'h1f, 8'hc3, 8'h00, 8'hff};

    initial begin
        axi_req_in = '{wstrb: 4'hf, default: '0};
        {ext4, ext5, ext6} = {8'h5a, 5'h1f, 8'hc3};
        {serial2_clock_drive_in, serial2_data_out_in} = 2'h3;
        uart2_transmit_line_in = 1'b1;
        i2c_release_in = 5'h1f;
        reset_n_in = 1'b0;
        idle(2);
        reset_n_in <= 1'b1;
        idle(4);
        for (int k = 0; k < 6; k++) begin
            rd(ra[k], rdv, rsp);
            chk("reset read", {24'h0, rv[k]}, rdv);
        end
        $display("test reset values done");
        wr(MFIO_P4_LATCH_ADDR, 8'h0f, rsp);
        idle(4);
        rd(MFIO_P4_LATCH_ADDR, rdv, rsp);
        chk("p4 latch", 32'h0f, rdv);
        wr(MFIO_P4_PIN_ADDR, 8'hff, rsp);
        chk("p4 pin write resp", MFIO_RESP_OKAY, rsp);
        rd(MFIO_P4_PIN_ADDR, rdv, rsp);
        chk("p4 pins", 32'h0a, rdv);
        chk("p4 oe open drain", 8'hf0, port4_pin_oe_out);
        wr(MFIO_P4_DRIVE_ADDR, 8'hff, rsp);
        idle(2);
        chk("p4 oe push pull", 8'hff, port4_pin_oe_out);
        chk("p4 out", 8'h0f, port4_pin_out);
        wr(MFIO_P4_LATCH_ADDR, 8'hff, rsp);
        wr(MFIO_P4_DRIVE_ADDR, 8'h00, rsp);
        // Peripherals pull low through latch ones
        {serial2_clock_drive_in, serial2_data_out_in} <= 2'h0;
        uart2_transmit_line_in <= 1'b0;
        idle(3);
        chk("p4 oe peripherals", 8'h64, port4_pin_oe_out);
        {serial2_clock_drive_in, serial2_data_out_in} <= 2'h3;
        uart2_transmit_line_in <= 1'b1;
        ext4 <= 8'ha5;
        idle(5);
        chk("p4 rx lines", 3'h0, {serial2_clock_line_out,
            serial2_data_in_out, uart2_receive_line_out});
        $display("test port 4 done");
        wr(MFIO_P5_LATCH_ADDR, 8'h1b, rsp);
        i2c_release_in <= 5'h1e;
        idle(4);
        rd(MFIO_P5_LATCH_ADDR, rdv, rsp);
        chk("p5 latch", 32'h1b, rdv);
        rd(MFIO_P5_PIN_ADDR, rdv, rsp);
        chk("p5 pins", 32'h1a, rdv);
        $display("test port 5 done");
        wr(MFIO_P6_DIR_ADDR, 8'h0f, rsp);
        wr(MFIO_P6_IE_ADDR, 8'h30, rsp);
        wr(MFIO_P6_LATCH_ADDR, 8'h55, rsp);
        idle(4);
        rd(MFIO_P6_LATCH_ADDR, rdv, rsp);
        chk("p6 data", 32'h05, rdv);
        chk("p6 oe", 8'h0f, port6_pin_oe_out);
        chk("p6 out", 8'h55, port6_pin_out);
        chk("analog select", 8'hc0, converter_input_select_out);
        chk("keywake", 4'hc, keywake_line_out);
        // Set port 6 bit 7; input bits take read value
        wr(MFIO_BITOP_ADDR, 8'h2f, rsp);
        idle(2);
        chk("bit op latch", 8'h85, port6_pin_out);
        $display("test port 6 done");
        wr(16'h0100, 8'h12, rsp);
        chk("unmapped write resp", MFIO_RESP_SLVERR, rsp);
        rd(16'h0100, rdv, rsp);
        chk("unmapped read resp", MFIO_RESP_SLVERR, rsp);
        chk("unmapped read data", 32'h0, rdv);
        $display("test refusals done");
        final_report();
    end
endmodule

`default_nettype wire
